/* File: bnc_node.v */
// memory bus node: confinement checks and notification filtering
// Functional notes
// - deliver notification only on own or global ID
// - notification is one packet, never answered
// - node holds processor ID loaded at init
// - interconnect registers decoded apart from memory
// - exactly 32 interconnect registers per node
// - node address is module plus bus number
// - two interlaced parity bits generated and checked
// - arbitration lines checked by duplicate compare
// - checker compares master bus drive, reports mismatch
// - check outgoing module data before bus release
// - check bus data before it enters module
// - controller request failure blamed on the bus
// - controller reply checked as it is driven
// - duplicated controller pair, master and checker
// - localize error, report it, then isolate
// - track all bus requests, depth three max
`timescale 1ns/1ns
`default_nettype none
`include "bnc_defines.vh"

module bnc_node #(
  parameter CW   = 17,
  parameter DW   = 32,
  parameter PIDW = 8,
  parameter ARBW = 4
) (
  // clock and reset
  input  wire            sys_clk,
  input  wire            nrst,
  // node configuration
  input  wire            role_mcu,
  input  wire            frc_checker,
  input  wire [5:0]      module_num,
  input  wire [2:0]      bus_num,
  input  wire            init_load,
  input  wire [PIDW-1:0] init_pid,
  // outgoing packets from inside the module
  input  wire            loc_valid,
  output wire            loc_ready,
  input  wire [CW-1:0]   loc_ctl,
  input  wire [DW-1:0]   loc_ad,
  input  wire [1:0]      loc_par,
  // packet driven onto the memory bus
  output reg             out_valid,
  output reg             out_en,
  output reg  [CW-1:0]   out_ctl,
  output reg  [DW-1:0]   out_ad,
  output reg  [1:0]      out_par,
  output reg             out_arb,
  output reg             out_arb_dup,
  // master drive seen on the bus, for the checker
  input  wire            obs_valid,
  input  wire [CW-1:0]   obs_ctl,
  input  wire [DW-1:0]   obs_ad,
  input  wire [1:0]      obs_par,
  // packets received from the memory bus
  input  wire            in_valid,
  input  wire [CW-1:0]   in_ctl,
  input  wire [DW-1:0]   in_ad,
  input  wire [1:0]      in_par,
  input  wire [ARBW-1:0] in_arb,
  input  wire [ARBW-1:0] in_arb_dup,
  // checked packets handed to the module
  output reg             mod_valid,
  output reg  [CW-1:0]   mod_ctl,
  output reg  [DW-1:0]   mod_ad,
  output reg             ipc_valid,
  output reg  [DW-1:0]   ipc_data,
  output reg             icr_rd_valid,
  output reg  [DW-1:0]   icr_rd_data,
  // error flags and state
  output reg             err_parity,
  output reg             err_arb,
  output reg             err_compare,
  output reg             err_local,
  output reg  [1:0]      err_area,
  output reg             isolated,
  output reg  [1:0]      pipe_depth
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function [1:0] pkt_kind(input [CW-1:0] ctl);
    pkt_kind = ctl[`BNC_KIND_MSB:`BNC_KIND_LSB];
  endfunction
  // node-local address match: module number plus bus number
  function node_hit(input [CW-1:0] ctl,
                    input [5:0]    mnum,
                    input [2:0]    bnum);
    node_hit = (ctl[`BNC_MOD_MSB:`BNC_MOD_LSB] == mnum) &&
               (ctl[`BNC_BUSN_MSB:`BNC_BUSN_LSB] == bnum);
  endfunction

  // -----------------------------------------------------------------
  // parity generation and checking
  // -----------------------------------------------------------------
  wire [1:0] loc_par_calc;
  wire [1:0] in_par_calc;
  bnc_ilpar #(
    .WIDTH (CW + DW)
  ) u_par_loc (
    .vec (   {loc_ctl, loc_ad}),
    .par (   loc_par_calc)
  );

  bnc_ilpar #(
    .WIDTH (CW + DW)
  ) u_par_in (
    .vec (   {in_ctl, in_ad}),
    .par (   in_par_calc)
  );

  // -----------------------------------------------------------------
  // interconnect registers and inbound decode
  // -----------------------------------------------------------------
  reg  [DW-1:0]   icr [0:`BNC_ICR_COUNT-1];
  wire [4:0]      in_idx  = in_ctl[`BNC_ICR_IDX_MSB:`BNC_ICR_IDX_LSB];
  wire [PIDW-1:0] proc_id = icr[`BNC_ICR_PID_IDX][PIDW-1:0];
  wire [1:0]      in_kind = pkt_kind(in_ctl);
  wire in_par_bad = in_valid && (in_par_calc != in_par);
  wire arb_bad    = (in_arb != in_arb_dup);
  wire in_ok      = in_valid && !in_par_bad && !arb_bad && !isolated;
  // interconnect space never aliases memory space: separate kind code
  wire in_is_icr  = (in_kind == `BNC_KIND_ICR) &&
                    node_hit(in_ctl, module_num, bus_num);
  wire pid_hit    = (in_ad[PIDW-1:0] == proc_id) ||
                    (in_ad[PIDW-1:0] == `BNC_PID_GLOBAL);

  // -----------------------------------------------------------------
  // outbound acceptance
  // -----------------------------------------------------------------
  wire loc_kind_req = (pkt_kind(loc_ctl) == `BNC_KIND_REQ);
  wire loc_take;
  wire loc_bad;
  wire cmp_bad;
  // a new request waits while the shared pipeline is full
  assign loc_ready = !isolated && !out_valid &&
                     (!loc_kind_req ||
                      pipe_depth != `BNC_MAX_DEPTH);
  assign loc_take  = loc_valid && loc_ready;
  assign loc_bad   = loc_take &&
                     (loc_par_calc != loc_par);
  // checker mirrors the master cycle for cycle; any skew is an error
  assign cmp_bad = frc_checker &&
                   ((obs_valid != out_valid) ||
                    (out_valid && ({obs_ctl, obs_ad, obs_par} !=
                                   {out_ctl, out_ad, out_par})));

  // -----------------------------------------------------------------
  // bus output stage
  // -----------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_valid   <= 1'b0;
      out_en      <= 1'b0;
      out_ctl     <= {CW{1'b0}};
      out_ad      <= {DW{1'b0}};
      out_par     <= 2'h0;
      out_arb     <= 1'b0;
      out_arb_dup <= 1'b0;
    end
    else
    begin
      // released only once its parity from inside the module held
      out_valid   <= loc_take && !loc_bad;
      // the checker computes the same word but never drives it
      out_en      <= loc_take && !loc_bad && !frc_checker;
      if (loc_take && !loc_bad)
      begin
        out_ctl <= loc_ctl;
        out_ad  <= loc_ad;
        out_par <= loc_par_calc;
      end
      out_arb     <= loc_valid && !isolated;
      out_arb_dup <= loc_valid && !isolated;
    end
  end

  // -----------------------------------------------------------------
  // pipeline tracking of every request on the bus
  // -----------------------------------------------------------------
  wire seen_req   = in_ok && (in_kind == `BNC_KIND_REQ);
  wire seen_reply = in_ok && (in_kind == `BNC_KIND_REPLY);

  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      pipe_depth <= 2'h0;
    else if (seen_req && !seen_reply && pipe_depth != `BNC_MAX_DEPTH)
      pipe_depth <= pipe_depth + 2'h1;
    else if (seen_reply && !seen_req && pipe_depth != 2'h0)
      pipe_depth <= pipe_depth - 2'h1;
  end

  // -----------------------------------------------------------------
  // delivery into the module
  // -----------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mod_valid    <= 1'b0;
      mod_ctl      <= {CW{1'b0}};
      mod_ad       <= {DW{1'b0}};
      ipc_valid    <= 1'b0;
      ipc_data     <= {DW{1'b0}};
      icr_rd_valid <= 1'b0;
      icr_rd_data  <= {DW{1'b0}};
    end
    else
    begin
      // controllers take requests, switches take replies
      mod_valid <= in_ok &&
                   ((role_mcu && in_kind == `BNC_KIND_REQ) ||
                    (!role_mcu && in_kind == `BNC_KIND_REPLY));
      if (in_ok)
      begin
        mod_ctl <= in_ctl;
        mod_ad  <= in_ad;
      end
      // notifications never touch the pipeline count or get a reply
      ipc_valid <= in_ok && !role_mcu && pid_hit &&
                   (in_kind == `BNC_KIND_NOTIFY);
      if (in_ok && in_kind == `BNC_KIND_NOTIFY)
        ipc_data <= in_ad;
      icr_rd_valid <= in_ok && in_is_icr && !in_ctl[`BNC_ICR_WR_BIT];
      if (in_ok && in_is_icr)
        icr_rd_data <= icr[in_idx];
    end
  end

  // -----------------------------------------------------------------
  // interconnect register writes
  // -----------------------------------------------------------------
  integer r;

  // initialization load takes precedence over a bus write
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      for (r = 0; r < `BNC_ICR_COUNT; r = r + 1)
        icr[r] <= {DW{1'b0}};
    else if (init_load)
      icr[`BNC_ICR_PID_IDX] <= {{(DW-PIDW){1'b0}}, init_pid};
    else if (in_ok && in_is_icr && in_ctl[`BNC_ICR_WR_BIT])
      icr[in_idx] <= in_ad;
  end

  // -----------------------------------------------------------------
  // error flags, confinement area and isolation
  // -----------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      err_parity  <= 1'b0;
      err_arb     <= 1'b0;
      err_compare <= 1'b0;
      err_local   <= 1'b0;
      err_area    <= `BNC_AREA_NONE;
      isolated    <= 1'b0;
    end
    else
    begin
      err_parity  <= in_par_bad && !isolated;
      err_arb     <= arb_bad && !isolated;
      err_compare <= cmp_bad && !isolated;
      err_local   <= loc_bad;
      // data checked clean on leaving its module, so a receive
      // failure belongs to the bus, including controller requests
      if (!isolated && (loc_bad || cmp_bad))
        err_area <= `BNC_AREA_MODULE;
      else if (!isolated && (in_par_bad || arb_bad))
        err_area <= `BNC_AREA_BUS;
      // sticky until reset; recovery lives outside this block
      if (loc_bad || cmp_bad || in_par_bad || arb_bad)
        isolated <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: bnc_defines.vh */
// shared constants for the bus node check and notification filter
`ifndef BNC_DEFINES_VH
`define BNC_DEFINES_VH

// packet kinds carried in the low control bits
`define BNC_KIND_LSB      0
`define BNC_KIND_MSB      1
`define BNC_KIND_REQ      2'h0
`define BNC_KIND_REPLY    2'h1
`define BNC_KIND_NOTIFY   2'h2
`define BNC_KIND_ICR      2'h3

// interconnect register access fields in the control word
`define BNC_ICR_WR_BIT    2
`define BNC_ICR_IDX_LSB   3
`define BNC_ICR_IDX_MSB   7
`define BNC_NODE_LSB      8
`define BNC_MOD_LSB       8
`define BNC_MOD_MSB       13
`define BNC_BUSN_LSB      14
`define BNC_BUSN_MSB      16
`define BNC_NODE_MSB      16

// register file and identifiers
`define BNC_ICR_COUNT     32
`define BNC_ICR_PID_IDX   5'h0_0
`define BNC_PID_RESET     8'h0_0
`define BNC_PID_GLOBAL    8'hf_f

// bus pipeline depth limit
`define BNC_MAX_DEPTH     2'h3

// confinement area reported with an error
`define BNC_AREA_NONE     2'h0
`define BNC_AREA_MODULE   2'h1
`define BNC_AREA_BUS      2'h2

`endif

/* File: bnc_ilpar.v */
// two interlaced parity bits over a bus word
`timescale 1ns/1ns
`default_nettype none

module bnc_ilpar #(
  parameter WIDTH = 49
) (
  // word to cover
  input  wire [WIDTH-1:0] vec,
  // bit 0 covers even positions, bit 1 odd positions
  output reg  [1:0]       par
);

  integer i;

  // interlacing lets one pair catch any two adjacent stuck lines
  always @*
  begin
    par = 2'h0;
    for (i = 0; i < WIDTH; i = i + 1)
    begin
      par[i % 2] = par[i % 2] ^ vec[i];
    end
  end

endmodule

`default_nettype wire

/* File: bnc_node_properties.sv */
// assertion checker for the bus node, bound to every instance
`timescale 1ns/1ns
`default_nettype none
module bnc_node_properties (
  // clock, reset and mode
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        role_mcu,
  input wire logic        frc_checker,
  // module side
  input wire logic        loc_valid,
  input wire logic        loc_ready,
  input wire logic [16:0] loc_ctl,
  input wire logic [31:0] loc_ad,
  input wire logic [1:0]  loc_par,
  input wire logic        out_valid,
  input wire logic [16:0] out_ctl,
  input wire logic [31:0] out_ad,
  input wire logic [1:0]  out_par,
  input wire logic [31:0] obs_ad,
  // bus side
  input wire logic        in_valid,
  input wire logic [16:0] in_ctl,
  input wire logic [31:0] in_ad,
  input wire logic [1:0]  in_par,
  input wire logic [3:0]  in_arb,
  input wire logic [3:0]  in_arb_dup,
  // results
  input wire logic        ipc_valid,
  input wire logic        err_parity,
  input wire logic        err_arb,
  input wire logic        err_compare,
  input wire logic        err_local,
  input wire logic [1:0]  err_area,
  input wire logic        isolated,
  input wire logic [1:0]  pipe_depth
);
  function automatic logic [1:0] vpar(input logic [48:0] w);
    vpar = {^(w & 49'h0_aaaa_aaaa_aaaa), ^(w & 49'h1_5555_5555_5555)};
  endfunction

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_par;
    in_valid && !isolated && in_par != vpar({in_ctl, in_ad})
      |=> err_parity;
  endproperty
  a_par: assert property (p_par) else $error("parity miss");
  property p_arb;
    in_arb != in_arb_dup && !isolated |=> err_arb;
  endproperty
  a_arb: assert property (p_arb) else $error("arb miss");
  property p_cmp;
    frc_checker && !isolated && out_valid && obs_ad != out_ad
      |=> err_compare;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare miss");
  property p_out;
    out_valid |-> out_par == vpar({out_ctl, out_ad});
  endproperty
  a_out: assert property (p_out) else $error("out parity bad");
  property p_local;
    loc_valid && loc_ready && loc_par != vpar({loc_ctl, loc_ad})
      |=> err_local && !out_valid;
  endproperty
  a_local: assert property (p_local) else $error("local leak");
  property p_iso;
    isolated |-> !loc_ready;
  endproperty
  a_iso: assert property (p_iso) else $error("isolated ready");
  property p_depth;
    loc_ctl[1:0] == 2'h0 && pipe_depth == 2'h3 |-> !loc_ready;
  endproperty
  a_depth: assert property (p_depth) else $error("deep ready");
  property p_ipc;
    ipc_valid |-> $past(in_valid && in_ctl[1:0] == 2'h2 && !role_mcu);
  endproperty
  a_ipc: assert property (p_ipc) else $error("stray notify");

  c_ipc: cover property (ipc_valid);
  c_cmp: cover property (err_compare);
  c_full: cover property (pipe_depth == 2'h3);
endmodule

bind bnc_node bnc_node_properties u_props (
  .sys_clk, .nrst, .role_mcu, .frc_checker, .loc_valid, .loc_ready,
  .loc_ctl, .loc_ad, .loc_par, .out_valid, .out_ctl, .out_ad, .out_par,
  .obs_ad, .in_valid, .in_ctl, .in_ad, .in_par, .in_arb, .in_arb_dup,
  .ipc_valid, .err_parity, .err_arb, .err_compare, .err_local,
  .err_area, .isolated, .pipe_depth);
`default_nettype wire

/* File: bnc_far_node.sv */
// far bus node model: puts packets on the node's receive lines
`timescale 1ns/1ns
`default_nettype none
module bnc_far_node (
  // clock and commands from the bench
  input  wire logic        sys_clk,
  input  wire logic        send,
  input  wire logic [16:0] s_ctl,
  input  wire logic [31:0] s_ad,
  input  wire logic        bad_par,
  input  wire logic        bad_arb,
  // bus lines
  output var  logic        in_valid,
  output var  logic [16:0] in_ctl,
  output var  logic [31:0] in_ad,
  output var  logic [1:0]  in_par,
  output var  logic [3:0]  in_arb,
  output var  logic [3:0]  in_arb_dup
);
  function automatic logic [1:0] vpar(input logic [48:0] w);
    vpar = {^(w & 49'h0_aaaa_aaaa_aaaa), ^(w & 49'h1_5555_5555_5555)};
  endfunction

  initial {in_valid, in_ctl, in_ad, in_par, in_arb, in_arb_dup} = '0;

  // idle control, address and parity lines toggle so a stale word is never mistaken for a packet
  always @(posedge sys_clk)
  begin
    in_valid <= send;
    in_ctl <= send ? s_ctl : ~in_ctl;
    in_ad <= send ? s_ad : ~in_ad;
    in_par <= send ? vpar({s_ctl, s_ad}) ^ {1'b0, bad_par} : ~in_par;
    in_arb <= {3'h0, send};
    in_arb_dup <= {3'h0, send} ^ {4{bad_arb}};
  end
endmodule
`default_nettype wire

/* File: bnc_node_tb_top.sv */
// testbench for the bus node against a far node model
`timescale 1ns/1ns
`default_nettype none
module bnc_node_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic role_mcu = 1'b0;
  logic frc_checker = 1'b0;
  logic obs_flip = 1'b0;
  logic init_load = 1'b0;
  logic [7:0] init_pid = 8'h00;
  logic loc_valid = 1'b0;
  logic [16:0] loc_ctl = 17'h0_0000;
  logic [31:0] loc_ad = 32'h0000_0000;
  logic [1:0] loc_par = 2'h0;
  logic send = 1'b0;
  logic bad_par = 1'b0;
  logic bad_arb = 1'b0;
  logic [16:0] s_ctl = 17'h0_0000;
  logic [31:0] s_ad = 32'h0000_0000;
  wire logic loc_ready, out_valid, out_en, out_arb, out_arb_dup, isolated;
  wire logic in_valid, mod_valid, ipc_valid, icr_rd_valid;
  wire logic err_parity, err_arb, err_compare, err_local;
  wire logic [16:0] out_ctl, in_ctl, mod_ctl;
  wire logic [31:0] out_ad, in_ad, mod_ad, ipc_data, icr_rd_data;
  wire logic [1:0] out_par, in_par, err_area, pipe_depth;
  wire logic [3:0] in_arb, in_arb_dup;
  int fails = 0;
  int n_tests = 0;

  bnc_node DUT (.sys_clk, .nrst, .role_mcu, .frc_checker,
    .module_num(6'h05), .bus_num(3'h2), .init_load, .init_pid,
    .loc_valid, .loc_ready, .loc_ctl, .loc_ad, .loc_par, .out_valid,
    .out_en, .out_ctl, .out_ad, .out_par, .out_arb, .out_arb_dup,
    .obs_valid(out_valid), .obs_ctl(out_ctl), .obs_par(out_par),
    .obs_ad({out_ad[31:1], out_ad[0] ^ obs_flip}), .in_valid, .in_ctl,
    .in_ad, .in_par, .in_arb, .in_arb_dup, .mod_valid, .mod_ctl, .mod_ad,
    .ipc_valid, .ipc_data, .icr_rd_valid, .icr_rd_data, .err_parity,
    .err_arb, .err_compare, .err_local, .err_area, .isolated, .pipe_depth);
  bnc_far_node u_far (.sys_clk, .send, .s_ctl, .s_ad, .bad_par, .bad_arb,
    .in_valid, .in_ctl, .in_ad, .in_par, .in_arb, .in_arb_dup);

  always #5 sys_clk = ~sys_clk;

  function automatic logic [1:0] vpar(input logic [48:0] w);
    vpar = {^(w & 49'h0_aaaa_aaaa_aaaa), ^(w & 49'h1_5555_5555_5555)};
  endfunction
  function automatic logic [16:0] icr(input logic [8:0] n, input logic w);
    return {n, 5'h1f, w, 2'h3};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rst();
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  // results of a packet are looked at just after the edge that takes it
  task automatic bus(input logic [16:0] c, input logic [31:0] a,
                     input logic bp = 1'b0, input logic ba = 1'b0);
    @(posedge sys_clk);
    send <= 1'b1;
    s_ctl <= c;
    s_ad <= a;
    bad_par <= bp;
    bad_arb <= ba;
    @(posedge sys_clk);
    send <= 1'b0;
    bad_arb <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic loc(input logic [16:0] c, input logic [31:0] a,
                     input logic [1:0] bp);
    @(posedge sys_clk);
    loc_valid <= 1'b1;
    loc_ctl <= c;
    loc_ad <= a;
    loc_par <= vpar({c, a}) ^ bp;
    @(posedge sys_clk);
    loc_valid <= 1'b0;
    #1;
  endtask

  task automatic t_pipe();
    rst();
    for (int i = 1; i < 5; i++)
    begin
      bus(17'h0_0000, 32'h0000_0100);
      chk("pipe_depth", pipe_depth, i > 3 ? 3 : i);
      chk("mod_valid", mod_valid, 1'b0);
    end
    chk("loc_ready", loc_ready, 1'b0);
    bus(17'h0_0001, 32'h5a5a_0f0f);
    chk("pipe_depth", pipe_depth, 2'h2);
    chk("mod_ad", {mod_valid, mod_ad[30:0]}, 32'hda5a_0f0f);
    chk("mod_ctl", mod_ctl, 32'h0000_0001);
    loc(17'h0_0000, 32'h8001_00c3, 2'h0);
    chk("out_valid", out_valid & out_en & out_arb_dup, 1'b1);
    chk("out_ad", out_ad, 32'h8001_00c3);
    chk("out_ctl", {out_arb, out_ctl}, 32'h0002_0000);
    chk("out_par", out_par, vpar({17'h0_0000, 32'h8001_00c3}));
    @(posedge sys_clk);
    role_mcu <= 1'b1;
    bus(17'h0_0000, 32'h0000_0040);
    chk("mod_valid", mod_valid, 1'b1);
    $display("test pipe done");
  endtask
  task automatic t_ipc();
    logic [7:0] pid[3] = '{8'h3d, 8'hff, 8'h3c};
    rst();
    role_mcu <= 1'b0;
    @(posedge sys_clk);
    init_load <= 1'b1;
    init_pid <= 8'h3c;
    @(posedge sys_clk);
    init_load <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      bus(17'h0_0002, {24'h00_0000, pid[i]});
      chk("ipc_valid", ipc_valid, i > 0);
      chk("pipe_depth", {mod_valid, pipe_depth}, 3'h0);
    end
    chk("ipc_data", ipc_data, 32'h0000_003c);
    $display("test ipc done");
  endtask
  task automatic t_icr();
    rst();
    bus(icr(9'h085, 1'b1), 32'hdead_beef);
    bus(icr(9'h0c5, 1'b1), 32'h1234_5678);
    bus(icr(9'h086, 1'b0), 32'h0000_0000);
    chk("icr_rd_valid", icr_rd_valid, 1'b0);
    bus(icr(9'h085, 1'b0), 32'h0000_0000);
    chk("icr_rd_valid", icr_rd_valid, 1'b1);
    chk("icr_rd_data", icr_rd_data, 32'hdead_beef);
    chk("mod_valid", {mod_valid, pipe_depth}, 3'h0);
    $display("test icr done");
  endtask
  task automatic t_err();
    for (int k = 0; k < 4; k++)
    begin
      rst();
      role_mcu <= k < 2;
      frc_checker <= k == 3;
      obs_flip <= k == 3;
      if (k == 1 || k == 2)
        bus(17'h0_0000, 32'h0000_0000, k == 1, k == 2);
      else
        loc(17'h0_0002, 32'h0000_0011, k == 0 ? 2'h1 : 2'h0);
      if (k == 3)
        chk("out_en", {out_valid, out_en}, 2'h2);
      // the compare sees the released word one edge later
      repeat (k / 3) @(posedge sys_clk);
      #1;
      chk("err_flags", {err_local, err_parity, err_arb, err_compare},
          4'h8 >> k);
      chk("err_area", err_area, k % 3 ? 2'h2 : 2'h1);
      chk("isolated", isolated & !loc_ready, 1'b1);
    end
    $display("test err done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    t_pipe();
    t_ipc();
    t_icr();
    t_err();
    stop_test();
  end

  // the tests take about ninety cycles; this is many times that
  initial
  begin
    #20_000;
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
